// ===== verilog/rwd_pkg.sv
// constants shared by the watchdog countdown block
package rwd_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] WDOG_CTRL_ADDR    = 8'h2d;
   localparam logic [7:0] WDOG_CTRL_RESET   = 8'h00;
   localparam int         REPEAT_BIT        = 7;
   localparam int         COUNT_MSB         = 6;
   localparam int         COUNT_LSB         = 2;
   localparam int         TICK_MSB          = 1;
   localparam int         TICK_LSB          = 0;
   localparam int         COUNT_W           = 5;
   localparam logic [4:0] COUNT_ZERO        = 5'h00;
   localparam logic [4:0] COUNT_ONE         = 5'h01;
   localparam logic       REPEAT_RESET      = 1'h0;
   localparam logic [1:0] TICK_SEL_RESET    = 2'h0;

   // ----------------------------------------------------------------
   // tick selection codes
   // ----------------------------------------------------------------
   localparam logic [1:0] TICK_4S           = 2'h0;
   localparam logic [1:0] TICK_1S           = 2'h1;
   localparam logic [1:0] TICK_QUARTER      = 2'h2;
   localparam logic [1:0] TICK_SIXTEENTH    = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         OSC_HZ            = 32768;
   localparam int         FASTEST_TICK_HZ   = 16;
   localparam int         OSC_PER_FAST_TICK = OSC_HZ / FASTEST_TICK_HZ;
   localparam int         PRESCALE_W        = 17;
   localparam int         CLK_HZ            = 40000000;
   localparam int         IRQ_PULSE_NS      = 1000;
   localparam int         IRQ_PULSE_CYCLES  = (IRQ_PULSE_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int         PULSE_CNT_W       = 6;

   // ----------------------------------------------------------------
   // countdown states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STOPPED = 3'h1,
      ST_RUNNING = 3'h2,
      ST_HELD    = 3'h4
   } rwd_state_e;

endpackage : rwd_pkg

// ===== verilog/rwd_tick_gen.sv
// oscillator synchroniser and step-rate prescaler
`timescale 1ns/1ps
module rwd_tick_gen #(
   parameter int OSC_PER_FAST_TICK = rwd_pkg::OSC_PER_FAST_TICK
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       osc_32k_i,
   input  wire logic [1:0] tick_sel_i,
   output logic            tick_o
);

   // ----------------------------------------------------------------
   // oscillator synchroniser
   // ----------------------------------------------------------------
   logic                               sync1_reg;
   logic                               sync2_reg;
   logic                               sync3_reg;
   logic                               osc_level_reg;
   logic [rwd_pkg::PRESCALE_W-1:0]     prescale_reg;
   logic [rwd_pkg::PRESCALE_W-1:0]     prescale_next;
   logic [rwd_pkg::PRESCALE_W-1:0]     ratio_mask;
   wire                                osc_agree;
   wire                                osc_rise;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_reg     <= 1'h0;
         sync2_reg     <= 1'h0;
         sync3_reg     <= 1'h0;
         osc_level_reg <= 1'h0;
      end else begin
         sync1_reg     <= osc_32k_i;
         sync2_reg     <= sync1_reg;
         sync3_reg     <= sync2_reg;
         if (osc_agree) begin
            osc_level_reg <= sync3_reg;
         end
      end
   end

   // a level only counts once two stages agree, so a glitch cannot step the divider
   assign osc_agree = (sync2_reg == sync3_reg);
   assign osc_rise  = osc_agree & sync3_reg & ~osc_level_reg;

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   // free running: reloads never restart it, so later periods stay exact
   assign prescale_next = prescale_reg + {{(rwd_pkg::PRESCALE_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prescale_reg <= '0;
      end else if (osc_rise) begin
         prescale_reg <= prescale_next;
      end
   end

   // each slower step is four times the previous one
   always_comb begin
      ratio_mask = rwd_pkg::PRESCALE_W'(OSC_PER_FAST_TICK - 1);
      unique case (tick_sel_i)
         rwd_pkg::TICK_SIXTEENTH: ratio_mask = rwd_pkg::PRESCALE_W'(OSC_PER_FAST_TICK - 1);
         rwd_pkg::TICK_QUARTER:   ratio_mask = rwd_pkg::PRESCALE_W'(OSC_PER_FAST_TICK * 4 - 1);
         rwd_pkg::TICK_1S:        ratio_mask = rwd_pkg::PRESCALE_W'(OSC_PER_FAST_TICK * 16 - 1);
         rwd_pkg::TICK_4S:        ratio_mask = rwd_pkg::PRESCALE_W'(OSC_PER_FAST_TICK * 64 - 1);
      endcase
   end

   assign tick_o = osc_rise & ((prescale_reg & ratio_mask) == ratio_mask);

endmodule : rwd_tick_gen

// ===== verilog/rwd_watchdog.sv
// watchdog countdown with control register and interrupt pin drive
// How it works
// - control bit 7 picks repeat (1) or single shot (0, default).
// - a write to bits 6..2 loads the counter, 0 to 1Fh, default 0.
// - reading bits 6..2 returns the live counter, not the written value.
// - bits 1..0 pick the step: 4 s, 1 s, 1/4 s, 1/16 s.
// - period equals loaded count times step, 62.5 ms up to 124 s.
// - every step is derived from the 32.768 kHz oscillator.
// - the counter steps down by one per selected tick.
// - loading zero stops the watchdog; nonzero starts it.
// - a new count replaces a running count at once.
// - first period may be one tick off; later periods are exact.
// - repeat mode sets the flag, reloads and restarts each period.
// - single shot sets the flag and holds the counter at zero.
// - the expiry flag stays set until the host clears it.
// - per-pin enable bits gate the watchdog interrupt onto each pin.
// - an enabled pin pulses per period end or follows the flag.
// - pulse mode pulses every period end even with the flag still set.
`timescale 1ns/1ps
module rwd_watchdog #(
   parameter int OSC_PER_FAST_TICK = rwd_pkg::OSC_PER_FAST_TICK
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       osc_32k_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       wdog_flag_clear_i,
   input  wire logic       wdog_irq_enable_pin_a_i,
   input  wire logic       wdog_irq_enable_pin_b_i,
   input  wire logic       irq_pulse_mode_a_i,
   input  wire logic       irq_pulse_mode_b_i,
   output logic            wdog_expired_flag_o,
   output logic            irq_out_a_n,
   output logic            irq_out_b_n
);

   // ----------------------------------------------------------------
   // pin drive decision, shared by both interrupt pins
   // ----------------------------------------------------------------
   function automatic logic irq_active(input logic enable,
                                       input logic pulse_mode,
                                       input logic flag,
                                       input logic pulse);
      logic active;
      active = 1'b0;
      if (enable) begin
         active = pulse_mode ? pulse : flag;
      end
      return active;
   endfunction : irq_active

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   rwd_pkg::rwd_state_e                 state_reg;
   rwd_pkg::rwd_state_e                 state_next;
   logic                                repeat_reg;
   logic [1:0]                          tick_sel_reg;
   logic [rwd_pkg::COUNT_W-1:0]         load_reg;
   logic [rwd_pkg::COUNT_W-1:0]         count_reg;
   logic [rwd_pkg::COUNT_W-1:0]         count_next;
   logic                                flag_reg;
   logic [rwd_pkg::PULSE_CNT_W-1:0]     pulse_cnt_reg;
   logic                                irq_a_n_reg;
   logic                                irq_b_n_reg;
   logic [7:0]                          rdata_reg;
   logic                                tick;
   logic                                period_end;

   wire                                 ctrl_hit;
   wire                                 ctrl_wr;
   wire                                 ctrl_rd;
   wire  [rwd_pkg::COUNT_W-1:0]         wr_count;
   wire                                 wr_repeat;
   wire  [1:0]                          wr_tick_sel;
   wire                                 count_is_one;
   wire                                 pulse_live;
   wire                                 irq_a_next;
   wire                                 irq_b_next;
   wire  [7:0]                          ctrl_read_value;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   assign ctrl_hit    = (reg_addr_i == rwd_pkg::WDOG_CTRL_ADDR);
   assign ctrl_wr     = ctrl_hit & reg_wr_i;
   assign ctrl_rd     = ctrl_hit & reg_rd_i;
   assign wr_repeat   = reg_wdata_i[rwd_pkg::REPEAT_BIT];
   assign wr_count    = reg_wdata_i[rwd_pkg::COUNT_MSB:rwd_pkg::COUNT_LSB];
   assign wr_tick_sel = reg_wdata_i[rwd_pkg::TICK_MSB:rwd_pkg::TICK_LSB];

   // live count, not the load value, is what software sees
   assign ctrl_read_value = {repeat_reg, count_reg, tick_sel_reg};

   // ----------------------------------------------------------------
   // mode, step and load value registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         repeat_reg   <= rwd_pkg::REPEAT_RESET;
         tick_sel_reg <= rwd_pkg::TICK_SEL_RESET;
         load_reg     <= rwd_pkg::COUNT_ZERO;
      end else if (ctrl_wr) begin
         repeat_reg   <= wr_repeat;
         tick_sel_reg <= wr_tick_sel;
         load_reg     <= wr_count;
      end
   end

   // ----------------------------------------------------------------
   // step tick source
   // ----------------------------------------------------------------
   rwd_tick_gen #(
      .OSC_PER_FAST_TICK (OSC_PER_FAST_TICK)
   ) u_tick_gen (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .osc_32k_i  (osc_32k_i),
      .tick_sel_i (tick_sel_reg),
      .tick_o     (tick)
   );

   // ----------------------------------------------------------------
   // countdown
   // ----------------------------------------------------------------
   assign count_is_one = (count_reg == rwd_pkg::COUNT_ONE);

   // the prescaler is not restarted by a write, hence the one-tick slack on a load
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      period_end = 1'b0;
      if (ctrl_wr) begin
         // a write overrides any tick landing in the same cycle
         count_next = wr_count;
         state_next = (wr_count == rwd_pkg::COUNT_ZERO) ?
                      rwd_pkg::ST_STOPPED : rwd_pkg::ST_RUNNING;
      end else begin
         unique case (state_reg)
            rwd_pkg::ST_STOPPED: begin
               count_next = count_reg;
            end
            rwd_pkg::ST_RUNNING: begin
               if (tick) begin
                  if (count_is_one) begin
                     period_end = 1'b1;
                     if (repeat_reg) begin
                        count_next = load_reg;
                     end else begin
                        count_next = rwd_pkg::COUNT_ZERO;
                        state_next = rwd_pkg::ST_HELD;
                     end
                  end else begin
                     count_next = count_reg - rwd_pkg::COUNT_ONE;
                  end
               end
            end
            rwd_pkg::ST_HELD: begin
               count_next = rwd_pkg::COUNT_ZERO;
            end
            default: begin
               state_next = rwd_pkg::ST_STOPPED;
               count_next = rwd_pkg::COUNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= rwd_pkg::ST_STOPPED;
         count_reg <= rwd_pkg::COUNT_ZERO;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // ----------------------------------------------------------------
   // expiry flag
   // ----------------------------------------------------------------
   // set beats clear so an expiry landing on the clear is not lost
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_reg <= 1'b0;
      end else if (period_end) begin
         flag_reg <= 1'b1;
      end else if (wdog_flag_clear_i) begin
         flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupt pulse stretcher
   // ----------------------------------------------------------------
   // restarts on every period end, independent of the flag state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_cnt_reg <= '0;
      end else if (period_end) begin
         pulse_cnt_reg <= rwd_pkg::PULSE_CNT_W'(rwd_pkg::IRQ_PULSE_CYCLES);
      end else if (pulse_live) begin
         pulse_cnt_reg <= pulse_cnt_reg - {{(rwd_pkg::PULSE_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign pulse_live = (pulse_cnt_reg != '0);

   // ----------------------------------------------------------------
   // interrupt pins
   // ----------------------------------------------------------------
   assign irq_a_next = irq_active(wdog_irq_enable_pin_a_i, irq_pulse_mode_a_i,
                                  flag_reg, pulse_live);
   assign irq_b_next = irq_active(wdog_irq_enable_pin_b_i, irq_pulse_mode_b_i,
                                  flag_reg, pulse_live);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_a_n_reg <= 1'b1;
         irq_b_n_reg <= 1'b1;
      end else begin
         irq_a_n_reg <= ~irq_a_next;
         irq_b_n_reg <= ~irq_b_next;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // unmapped addresses read zero; the control word is sampled on the read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= rwd_pkg::WDOG_CTRL_RESET;
      end else if (reg_rd_i) begin
         rdata_reg <= ctrl_rd ? ctrl_read_value : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o         = rdata_reg;
   assign wdog_expired_flag_o = flag_reg;
   assign irq_out_a_n         = irq_a_n_reg;
   assign irq_out_b_n         = irq_b_n_reg;

endmodule : rwd_watchdog

// ===== sim/rwd_monitor.sv
// port assertions for the watchdog countdown block
`timescale 1ns/1ps
module rwd_monitor (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       osc_32k_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       wdog_flag_clear_i,
   input wire logic       wdog_irq_enable_pin_a_i,
   input wire logic       wdog_irq_enable_pin_b_i,
   input wire logic       irq_pulse_mode_a_i,
   input wire logic       irq_pulse_mode_b_i,
   input wire logic       wdog_expired_flag_o,
   input wire logic       irq_out_a_n,
   input wire logic       irq_out_b_n
);
   // ----------------------------------------------------------------
   // low-time counter of pin a, wraps in long level lows (unchecked)
   // ----------------------------------------------------------------
   logic [5:0] low_a_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_a_reg <= 6'h00;
      end else begin
         low_a_reg <= irq_out_a_n ? 6'h00 : low_a_reg + 6'h01;
      end
   end
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   level_pin_a_a: assert property (
      !irq_pulse_mode_a_i && $past(!irq_pulse_mode_a_i) |-> irq_out_a_n ==
      !($past(wdog_irq_enable_pin_a_i) && $past(wdog_expired_flag_o))) else $error("level pin a");
   pulse_width_a: assert property (
      irq_pulse_mode_a_i && $rose(irq_out_a_n) |-> low_a_reg == rwd_pkg::IRQ_PULSE_CYCLES)
      else $error("pulse width on pin a");
   pulse_start_a: assert property (
      irq_pulse_mode_a_i && wdog_irq_enable_pin_a_i && $rose(wdog_expired_flag_o)
      |=> !irq_out_a_n) else $error("no pulse on pin a");
   pin_b_off_a: assert property (
      !wdog_irq_enable_pin_b_i && $past(!wdog_irq_enable_pin_b_i) |-> irq_out_b_n)
      else $error("disabled pin b driven");
   flag_hold_a: assert property (
      wdog_expired_flag_o && !wdog_flag_clear_i |=> wdog_expired_flag_o)
      else $error("flag dropped without clear");
   read_other_a: assert property (
      reg_rd_i && reg_addr_i != rwd_pkg::WDOG_CTRL_ADDR |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   read_mode_a: assert property (
      reg_rd_i && !reg_wr_i && reg_addr_i == rwd_pkg::WDOG_CTRL_ADDR && $past(reg_wr_i, 2)
      && $past(reg_addr_i, 2) == rwd_pkg::WDOG_CTRL_ADDR |=> {reg_rdata_o[7], reg_rdata_o[1:0]}
      == {$past(reg_wdata_i[7], 3), $past(reg_wdata_i[1:0], 3)}) else $error("mode or step");
   rdata_hold_a: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
endmodule : rwd_monitor

// ===== sim/rwd_host_model.sv
// host model driving the watchdog register strobes
`timescale 1ns/1ps
module rwd_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o
);
   initial {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h00000;
   // released lines show the inverse so stale values never pass
   task write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      #2;
      reg_addr_o  = addr;
      reg_wdata_o = data;
      reg_wr_o    = 1'h1;
      @(posedge clk_i);
      #2;
      reg_wr_o    = 1'h0;
      reg_addr_o  = ~addr;
      reg_wdata_o = ~data;
   endtask : write_reg
   task read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_i);
      #2;
      reg_addr_o = addr;
      reg_rd_o   = 1'h1;
      @(posedge clk_i);
      #2;
      reg_rd_o   = 1'h0;
      reg_addr_o = ~addr;
      data       = reg_rdata_i;
   endtask : read_reg
   // the count moves during a read, so two matching reads are needed
   task read_twice(output logic [7:0] data);
      logic [7:0] first;
      for (int i = 0; i < 4; i++) begin
         read_reg(rwd_pkg::WDOG_CTRL_ADDR, first);
         read_reg(rwd_pkg::WDOG_CTRL_ADDR, data);
         if (first === data) break;
      end
   endtask : read_twice
endmodule : rwd_host_model

// ===== sim/rwd_watchdog_tb.sv
// self-checking bench for the watchdog countdown block
`timescale 1ns/1ps
module rwd_watchdog_tb;
   logic        clk_i, rst_i, osc_32k_i, wr, rd, clr, en_a, en_b, pm_a, pm_b;
   logic [7:0]  addr, wdata, rdata, d;
   logic        flag, irq_a_n, irq_b_n;
   int          fails, checked, n;
   logic [7:0]  row_wd  [5] = '{8'h87, 8'h8a, 8'h85, 8'h84, 8'hff};
   logic [15:0] row_cyc [5] = '{16'h0050, 16'h0280, 16'h0500, 16'h1400, 16'h09b0};
   rwd_watchdog #(.OSC_PER_FAST_TICK(4)) u_rwd_watchdog (.clk_i(clk_i), .rst_i(rst_i),
      .osc_32k_i(osc_32k_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .wdog_flag_clear_i(clr),
      .wdog_irq_enable_pin_a_i(en_a), .wdog_irq_enable_pin_b_i(en_b),
      .irq_pulse_mode_a_i(pm_a), .irq_pulse_mode_b_i(pm_b), .wdog_expired_flag_o(flag),
      .irq_out_a_n(irq_a_n), .irq_out_b_n(irq_b_n));
   rwd_host_model u_rwd_host_model (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
   initial begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end
   // crystal runs free, 20 clocks per cycle keeps every period exact
   initial begin
      osc_32k_i = 1'h0;
      forever #250 osc_32k_i = ~osc_32k_i;
   end
   task check(input string name, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task results;
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   task tick(input int k);
      repeat (k) @(posedge clk_i);
      #2;
   endtask : tick
   // bounded wait for flag (sel 1) or pin a (sel 0) to reach v, cycles add to n
   task wait_lvl(input logic sel, input logic v, input int lim);
      while ((sel ? flag : irq_a_n) !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         fails++;
         results();
      end
   endtask : wait_lvl
   initial begin
      {rst_i, clr, en_a, en_b, pm_a, pm_b} = 6'h22;
      fails = 0;
      checked = 0;
      tick(16);
      rst_i = 1'h0;
      check("flag", flag, 1'h0);
      check("pin a", irq_a_n, 1'h1);
      u_rwd_host_model.write_reg(8'h2c, 8'hff);
      u_rwd_host_model.read_reg(8'h2c, d);
      check("unmapped", d, 8'h00);
      u_rwd_host_model.read_reg(8'h2d, d);
      check("ctrl reset", d, 8'h00);
      en_a = 1'h1;
      for (int i = 0; i < 5; i++) begin
         u_rwd_host_model.write_reg(8'h2d, row_wd[i]);
         n = 0;
         wait_lvl(1'h0, 1'h1, 12000);
         wait_lvl(1'h0, 1'h0, 12000);
         n = 0;
         wait_lvl(1'h0, 1'h1, 12000);
         wait_lvl(1'h0, 1'h0, 12000);
         check("period", n[15:0], row_cyc[i]);
      end
      check("flag kept", flag, 1'h1);
      u_rwd_host_model.write_reg(8'h2d, 8'h03);
      u_rwd_host_model.read_reg(8'h2d, d);
      check("stopped", d, 8'h03);
      clr = 1'h1;
      tick(1);
      clr = 1'h0;
      tick(400);
      check("no expiry", flag, 1'h0);
      u_rwd_host_model.write_reg(8'h2d, 8'h53);
      tick(250);
      u_rwd_host_model.read_twice(d);
      check("live count", d[6:2] > 5'h0f && d[6:2] < 5'h14, 1'h1);
      check("mode step", d[7:0] & 8'h83, 8'h03);
      {en_b, pm_b, pm_a} = 3'h6;
      u_rwd_host_model.write_reg(8'h2d, 8'h0b);
      n = 0;
      wait_lvl(1'h1, 1'h1, 260);
      tick(1);
      check("level a", irq_a_n, 1'h0);
      check("pulse b", irq_b_n, 1'h0);
      tick(400);
      u_rwd_host_model.read_twice(d);
      check("held zero", d, 8'h03);
      check("flag stays", flag, 1'h1);
      check("pulse end", irq_b_n, 1'h1);
      clr = 1'h1;
      tick(1);
      clr = 1'h0;
      tick(2);
      check("cleared", flag, 1'h0);
      check("level off", irq_a_n, 1'h1);
      results();
   end
endmodule : rwd_watchdog_tb
bind rwd_watchdog rwd_monitor u_rwd_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .osc_32k_i(osc_32k_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .wdog_flag_clear_i(wdog_flag_clear_i),
   .wdog_irq_enable_pin_a_i(wdog_irq_enable_pin_a_i),
   .wdog_irq_enable_pin_b_i(wdog_irq_enable_pin_b_i), .irq_pulse_mode_a_i(irq_pulse_mode_a_i),
   .irq_pulse_mode_b_i(irq_pulse_mode_b_i), .wdog_expired_flag_o(wdog_expired_flag_o),
   .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n));
